// ===== bssp_top.sv
// Device side of a double data rate two word burst SRAM synchronous port.
`timescale 1ns/100ps
`default_nettype none
`include "bssp_params.svh"

module bssp_top #(
    parameter int WIDTH = `BSSP_WORD_W,
    parameter int ADDR_W = `BSSP_ADDR_W,
    parameter int CNT_W = `BSSP_CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic k_clk,
    input wire logic k_n_clk,
    input wire logic load_strobe_n,
    input wire logic read_not_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WIDTH/`BSSP_LANE_W-1:0] byte_lane_select_n,
    input wire logic [WIDTH-1:0] dq_in,
    output logic [WIDTH-1:0] dq_out,
    output logic dq_oe,
    output logic output_valid_flag,
    output logic echo_clock,
    output logic echo_clock_n,
    input wire logic pll_disable_n,
    output logic legacy_mode,
    output logic [CNT_W-1:0] read_burst_count,
    output logic [CNT_W-1:0] write_burst_count
);

    localparam int LANES = WIDTH / `BSSP_LANE_W;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (WIDTH != `BSSP_LANE_W * 2 && WIDTH != `BSSP_LANE_W * 4)
        begin : g_bad_width
            $error("bssp_top supports only the narrow and wide organisations");
        end
        if (ADDR_W < 1 || CNT_W < 1)
        begin : g_bad_size
            $error("bssp_top address and counter widths must be positive");
        end
    endgenerate

    // ************************************************************
    // Declarations
    // ************************************************************
    logic k_rst;
    logic kn_rst;
    logic k_pll_on;
    bssp_pkg::bssp_lat_t lat_mode;
    logic cmd_rd;
    logic cmd_wr;
    logic [ADDR_W-1:0] cmd_addr;
    logic rd2_v;
    logic [ADDR_W-1:0] rd2_addr;
    logic launch_v;
    logic [ADDR_W-1:0] launch_addr;
    logic wdat_v;
    logic [ADDR_W-1:0] wdat_addr;
    logic [WIDTH-1:0] w0_data;
    logic [LANES-1:0] w0_lane;
    logic [WIDTH-1:0] w1_data;
    logic [LANES-1:0] w1_lane;
    logic fwd_hit;
    logic [`BSSP_ARRAYS-1:0][WIDTH-1:0] wr_word;
    logic [`BSSP_ARRAYS-1:0][LANES-1:0] wr_lanes;
    logic [`BSSP_ARRAYS-1:0][WIDTH-1:0] arr_rd;
    logic [`BSSP_ARRAYS-1:0][WIDTH-1:0] next_q;
    logic [WIDTH-1:0] q_pos;
    logic [WIDTH-1:0] q_hold;
    logic oe_pos;
    logic [WIDTH-1:0] q_neg;
    logic oe_neg;
    logic rd_tog;
    logic wr_tog;
    logic [2:0] clk_sync;
    logic rd_tog_seen;
    logic wr_tog_seen;

    // ************************************************************
    // Reset and mode crossings
    // ************************************************************
    // The system reset reaches both link domains through synchronisers.
    // The link clocks must run while reset is held, or the link stays dead.
    bssp_sync #(
        .W(2)
    ) u_k_sync (
        .clk(k_clk),
        .d({rst, pll_disable_n}),
        .q({k_rst, k_pll_on})
    );

    bssp_sync #(
        .W(1)
    ) u_kn_sync (
        .clk(k_n_clk),
        .d(rst),
        .q(kn_rst)
    );

    // Latency mode; changing the pin during traffic corrupts bursts in flight.
    always_ff @(posedge k_clk)
    begin
        if (k_rst)
        begin
            lat_mode <= bssp_pkg::BSSP_LAT_FULL;
        end
        else if (k_pll_on)
        begin
            lat_mode <= bssp_pkg::BSSP_LAT_FULL;
        end
        else
        begin
            lat_mode <= bssp_pkg::BSSP_LAT_LEGACY;
        end
    end

    // ************************************************************
    // Command capture on the positive input clock
    // ************************************************************
    // Strobe, direction and address are sampled only at positive rises.
    always_ff @(posedge k_clk)
    begin
        if (k_rst)
        begin
            cmd_rd <= 1'b0;
            cmd_wr <= 1'b0;
            cmd_addr <= '0;
        end
        else
        begin
            cmd_rd <= !load_strobe_n && read_not_write;
            cmd_wr <= !load_strobe_n && !read_not_write;
            cmd_addr <= addr;
        end
    end

    // ************************************************************
    // Read pipeline
    // ************************************************************
    // A second stage supplies the extra cycle of the full latency mode.
    always_ff @(posedge k_clk)
    begin
        if (k_rst)
        begin
            rd2_v <= 1'b0;
            rd2_addr <= '0;
        end
        else
        begin
            rd2_v <= cmd_rd;
            rd2_addr <= cmd_addr;
        end
    end

    // Legacy mode launches one positive rise after the command, full mode two.
    always_comb
    begin
        if (lat_mode == bssp_pkg::BSSP_LAT_LEGACY)
        begin
            launch_v = cmd_rd;
            launch_addr = cmd_addr;
        end
        else
        begin
            launch_v = rd2_v;
            launch_addr = rd2_addr;
        end
    end

    // ************************************************************
    // Write data capture
    // ************************************************************
    // Word one arrives at the positive rise after the command.
    always_ff @(posedge k_clk)
    begin
        if (k_rst)
        begin
            wdat_v <= 1'b0;
            wdat_addr <= '0;
            w0_data <= '0;
            w0_lane <= '0;
        end
        else
        begin
            wdat_v <= cmd_wr;
            wdat_addr <= cmd_addr;
            if (cmd_wr)
            begin
                w0_data <= dq_in;
                w0_lane <= ~byte_lane_select_n;
            end
        end
    end

    // Word two is taken at the negative rise that follows word one.
    // An idle half cycle clears the lane mask so nothing stale is written.
    always_ff @(posedge k_n_clk)
    begin
        if (kn_rst)
        begin
            w1_data <= '0;
            w1_lane <= '0;
        end
        else if (wdat_v)
        begin
            w1_data <= dq_in;
            w1_lane <= ~byte_lane_select_n;
        end
        else
        begin
            w1_lane <= '0;
        end
    end

    // ************************************************************
    // Storage arrays and forwarding
    // ************************************************************
    // The burst commits at the positive rise after word two, one word per array.
    assign wr_word[0] = w0_data;
    assign wr_word[1] = w1_data;
    assign wr_lanes[0] = w0_lane;
    assign wr_lanes[1] = w1_lane;

    // The write being committed at this edge is not yet in the array.
    assign fwd_hit = wdat_v && (wdat_addr == launch_addr);

    generate
        for (genvar g = 0; g < `BSSP_ARRAYS; g++)
        begin : g_arr
            bssp_array #(
                .ADDR_W(ADDR_W),
                .LANES(LANES)
            ) u_array (
                .clk(k_clk),
                .wr_en(wdat_v),
                .wr_addr(wdat_addr),
                .wr_data(wr_word[g]),
                .wr_lane_en(wr_lanes[g]),
                .rd_addr(launch_addr),
                .rd_data(arr_rd[g])
            );

            // Forwarded lanes replace only the bytes that the write enabled.
            for (genvar l = 0; l < LANES; l++)
            begin : g_fwd
                assign next_q[g][l*`BSSP_LANE_W +: `BSSP_LANE_W] =
                    (fwd_hit && wr_lanes[g][l]) ?
                    wr_word[g][l*`BSSP_LANE_W +: `BSSP_LANE_W] :
                    arr_rd[g][l*`BSSP_LANE_W +: `BSSP_LANE_W];
            end
        end
    endgenerate

    // ************************************************************
    // Read data launch
    // ************************************************************
    // Word one launches on the positive rise, word two is held for the negative.
    always_ff @(posedge k_clk)
    begin
        if (k_rst)
        begin
            q_pos <= '0;
            q_hold <= '0;
            oe_pos <= 1'b0;
        end
        else
        begin
            oe_pos <= launch_v;
            if (launch_v)
            begin
                q_pos <= next_q[0];
                q_hold <= next_q[1];
            end
        end
    end

    // The negative rise launches word two, or floats the bus after a burst.
    always_ff @(posedge k_n_clk)
    begin
        if (kn_rst)
        begin
            q_neg <= '0;
            oe_neg <= 1'b0;
        end
        else
        begin
            q_neg <= q_hold;
            oe_neg <= oe_pos;
        end
    end

    // ************************************************************
    // Pin outputs
    // ************************************************************
    // The clock level picks the half cycle, as a double rate output cell does.
    // This assumes the negative clock rises when the positive clock falls.
    assign dq_out = k_clk ? q_pos : q_neg;
    assign dq_oe = k_clk ? oe_pos : oe_neg;
    assign output_valid_flag = k_clk ? oe_pos : oe_neg;

    // The echo pair runs in all modes and through reset.
    assign echo_clock = k_clk;
    assign echo_clock_n = k_n_clk;

    // ************************************************************
    // Burst event crossing into the system domain
    // ************************************************************
    // Each finished burst flips a toggle, which survives the domain crossing.
    always_ff @(posedge k_clk)
    begin
        if (k_rst)
        begin
            rd_tog <= 1'b0;
            wr_tog <= 1'b0;
        end
        else
        begin
            rd_tog <= rd_tog ^ launch_v;
            wr_tog <= wr_tog ^ wdat_v;
        end
    end

    bssp_sync #(
        .W(3)
    ) u_clk_sync (
        .clk(clk),
        .d({rd_tog, wr_tog, pll_disable_n}),
        .q(clk_sync)
    );

    // Counters wrap; bursts closer than three system cycles may be missed.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_tog_seen <= 1'b0;
            wr_tog_seen <= 1'b0;
            read_burst_count <= '0;
            write_burst_count <= '0;
            legacy_mode <= 1'b0;
        end
        else
        begin
            rd_tog_seen <= clk_sync[2];
            wr_tog_seen <= clk_sync[1];
            legacy_mode <= !clk_sync[0];
            if (clk_sync[2] != rd_tog_seen)
            begin
                read_burst_count <= read_burst_count + 1'b1;
            end
            if (clk_sync[1] != wr_tog_seen)
            begin
                write_burst_count <= write_burst_count + 1'b1;
            end
        end
    end

endmodule : bssp_top
`default_nettype wire

// ===== bssp_params.svh
// Timing, width and layout constants of the burst SRAM synchronous port.
`ifndef BSSP_PARAMS_SVH
`define BSSP_PARAMS_SVH

// ************************************************************
// Organisation
// ************************************************************
`define BSSP_WORD_W 18
`define BSSP_ADDR_W 21
`define BSSP_LANE_W 9
`define BSSP_ARRAYS 2
`define BSSP_BURST_LEN 2

// ************************************************************
// Clocks, modes and counters
// ************************************************************
`define BSSP_CLK_MHZ 100
`define BSSP_LEGACY_MAX_MHZ 167
`define BSSP_CNT_W 16

`endif

// ===== bssp_pkg.sv
// Types shared by the burst SRAM synchronous port modules.
`default_nettype none

package bssp_pkg;

    // Read latency mode, chosen by the PLL disable pin.
    typedef enum logic {
        BSSP_LAT_FULL,
        BSSP_LAT_LEGACY
    } bssp_lat_t;

endpackage : bssp_pkg
`default_nettype wire

// ===== bssp_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "bssp_params.svh"

module bssp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output var logic [W-1:0] q
);

    // ************************************************************
    // Synchroniser stages
    // ************************************************************
    logic [W-1:0] stage1;

    generate
        if (W < 1)
        begin : g_bad_width
            $error("bssp_sync width must be at least one");
        end
    endgenerate

    // The first stage is read only by the second; it may be metastable.
    // No reset here, so the chain also serves as a reset synchroniser.
    always_ff @(posedge clk)
    begin
        stage1 <= d;
        q <= stage1;
    end

endmodule : bssp_sync
`default_nettype wire

// ===== bssp_array.sv
// One storage array of the burst SRAM, with per byte lane write enables.
`timescale 1ns/100ps
`default_nettype none
`include "bssp_params.svh"

module bssp_array #(
    parameter int ADDR_W = `BSSP_ADDR_W,
    parameter int LANES = `BSSP_WORD_W / `BSSP_LANE_W
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [LANES*`BSSP_LANE_W-1:0] wr_data,
    input wire logic [LANES-1:0] wr_lane_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [LANES*`BSSP_LANE_W-1:0] rd_data
);

    localparam int DEPTH = 2 ** ADDR_W;

    // ************************************************************
    // Per lane storage
    // ************************************************************
    // Each lane owns its own array, so a masked lane is simply not written.
    generate
        for (genvar l = 0; l < LANES; l++)
        begin : g_lane
            logic [`BSSP_LANE_W-1:0] mem [0:DEPTH-1];

            // A lane whose select was inactive keeps its stored byte.
            always_ff @(posedge clk)
            begin
                if (wr_en && wr_lane_en[l])
                begin
                    mem[wr_addr] <= wr_data[l*`BSSP_LANE_W +: `BSSP_LANE_W];
                end
            end

            // Read is asynchronous; the caller registers the result.
            assign rd_data[l*`BSSP_LANE_W +: `BSSP_LANE_W] = mem[rd_addr];
        end
    endgenerate

endmodule : bssp_array
`default_nettype wire

// ===== bssp_top_props.sv
// Concurrent checks of the burst SRAM port, bound to its top module.
`timescale 1ns/100ps
`default_nettype none

module bssp_props #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic k_clk,
    input wire logic k_n_clk,
    input wire logic load_strobe_n,
    input wire logic read_not_write,
    input wire logic dq_oe,
    input wire logic output_valid_flag,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic pll_disable_n,
    input wire logic legacy_mode,
    input wire logic [CNT_W-1:0] read_burst_count,
    input wire logic [CNT_W-1:0] write_burst_count
);
    // ************************************************************
    // Link side, sampled at the K# rise while a command is still held.
    // The sampled pins there still show the half cycle of the last K rise.
    // ************************************************************
    read_full_a: assert property (@(negedge k_clk) disable iff (rst)
        !load_strobe_n && read_not_write && !legacy_mode |->
        ##1 !output_valid_flag ##1 !output_valid_flag ##1 output_valid_flag)
        else $error("full latency read word not launched at the second rise");
    read_legacy_a: assert property (@(negedge k_clk) disable iff (rst)
        !load_strobe_n && read_not_write && legacy_mode |->
        ##1 !output_valid_flag ##1 output_valid_flag)
        else $error("legacy read word not launched at the next rise");
    write_quiet_a: assert property (@(negedge k_clk) disable iff (rst)
        !load_strobe_n && !read_not_write |->
        !output_valid_flag ##1 !output_valid_flag ##1 !output_valid_flag)
        else $error("valid flag raised during a write burst");
    idle_float_a: assert property (@(negedge k_clk) disable iff (rst)
        load_strobe_n [*4] |-> !dq_oe)
        else $error("data bus still driven after four idle cycles");
    // ************************************************************
    // Pin relations and status, seen on the system clock.
    // ************************************************************
    echo_pair_a: assert property (@(posedge clk) disable iff (rst)
        echo_clock == k_clk && echo_clock_n == k_n_clk && echo_clock != echo_clock_n)
        else $error("echo clocks do not follow the input clocks");
    valid_enable_a: assert property (@(posedge clk) disable iff (rst)
        output_valid_flag == dq_oe)
        else $error("valid flag differs from the bus enable");
    count_step_a: assert property (@(posedge clk) disable iff (rst)
        $changed(write_burst_count) |-> write_burst_count == $past(write_burst_count) + 1'b1)
        else $error("write burst count moved by other than one");
    reset_state_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> read_burst_count == '0 && write_burst_count == '0 && !dq_oe)
        else $error("status not cleared by reset");
    legacy_on_a: assert property (@(posedge clk) disable iff (rst)
        !pll_disable_n [*5] |-> legacy_mode)
        else $error("legacy mode not entered with the pll pin low");
    legacy_off_a: assert property (@(posedge clk) disable iff (rst)
        pll_disable_n [*5] |-> !legacy_mode)
        else $error("legacy mode held with the pll pin high");
endmodule : bssp_props

bind bssp_top bssp_props #(.CNT_W(CNT_W)) bssp_props_i (.clk(clk), .rst(rst), .k_clk(k_clk),
    .k_n_clk(k_n_clk), .load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
    .dq_oe(dq_oe), .output_valid_flag(output_valid_flag), .echo_clock(echo_clock),
    .echo_clock_n(echo_clock_n), .pll_disable_n(pll_disable_n), .legacy_mode(legacy_mode),
    .read_burst_count(read_burst_count), .write_burst_count(write_burst_count));

`default_nettype wire

// ===== bssp_ctrl.sv
// Memory controller model that drives commands and data of the burst port.
`timescale 1ns/100ps
`default_nettype none

module bssp_ctrl #(
    parameter int AW = 8,
    parameter int W = 18
) (
    input wire logic k_clk,
    input wire logic legacy,
    output logic load_strobe_n,
    output logic read_not_write,
    output logic [AW-1:0] addr,
    output logic [W/9-1:0] byte_lane_select_n,
    output logic [W-1:0] dq_in,
    input wire logic [W-1:0] dq_out,
    input wire logic dq_oe
);
    // Idle bus at time zero; every task is entered just after a K rise.
    initial
    begin
        load_strobe_n = 1'b1;
        read_not_write = 1'b0;
        addr = '0;
        byte_lane_select_n = '1;
        dq_in = '0;
    end

    // Write burst: word one at rise n+1, word two at the K# rise after it.
    task automatic wr(input logic [AW-1:0] a, input logic [W-1:0] d0, input logic [W-1:0] d1,
        input logic [W/9-1:0] s0, input logic [W/9-1:0] s1);
        load_strobe_n = 1'b0;
        read_not_write = 1'b0;
        addr = a;
        @(posedge k_clk);
        #1;
        load_strobe_n = 1'b1;
        addr = ~a;
        dq_in = d0;
        byte_lane_select_n = s0;
        @(posedge k_clk);
        #1;
        dq_in = d1;
        byte_lane_select_n = s1;
        @(negedge k_clk);
        #1;
        // Released data lines show the inverse so a stale capture is visible.
        dq_in = ~d1;
        byte_lane_select_n = '1;
        repeat (2) @(posedge k_clk);
        #1;
    endtask : wr

    // Read burst: samples both words and the bus enable a step after launch.
    task automatic rd(input logic [AW-1:0] a, output logic [W-1:0] w0, output logic [W-1:0] w1,
        output logic [1:0] v);
        load_strobe_n = 1'b0;
        read_not_write = 1'b1;
        addr = a;
        @(posedge k_clk);
        #1;
        load_strobe_n = 1'b1;
        read_not_write = 1'b0;
        addr = ~a;
        repeat (legacy ? 1 : 2) @(posedge k_clk);
        #1;
        w0 = dq_out;
        v[0] = dq_oe;
        @(negedge k_clk);
        #1;
        w1 = dq_out;
        v[1] = dq_oe;
        // Three idle rises let the bus float before the next command.
        repeat (3) @(posedge k_clk);
        #1;
    endtask : rd

    // Write then read of one address: the read command rides on word one.
    task automatic wr_rd(input logic [AW-1:0] a, input logic [W-1:0] d0, input logic [W-1:0] d1,
        input logic [W/9-1:0] s0, input logic [W/9-1:0] s1, output logic [W-1:0] w0,
        output logic [W-1:0] w1, output logic [1:0] v);
        load_strobe_n = 1'b0;
        read_not_write = 1'b0;
        addr = a;
        @(posedge k_clk);
        #1;
        read_not_write = 1'b1;
        dq_in = d0;
        byte_lane_select_n = s0;
        @(posedge k_clk);
        #1;
        load_strobe_n = 1'b1;
        read_not_write = 1'b0;
        addr = ~a;
        dq_in = d1;
        byte_lane_select_n = s1;
        @(negedge k_clk);
        #1;
        dq_in = ~d1;
        byte_lane_select_n = '1;
        repeat (legacy ? 1 : 2) @(posedge k_clk);
        #1;
        w0 = dq_out;
        v[0] = dq_oe;
        @(negedge k_clk);
        #1;
        w1 = dq_out;
        v[1] = dq_oe;
        repeat (3) @(posedge k_clk);
        #1;
    endtask : wr_rd
endmodule : bssp_ctrl

`default_nettype wire

// ===== burst_sram_sync_port_bench.sv
// Self-checking bench of the burst SRAM port with a reference memory model.
`timescale 1ns/100ps
`default_nettype none

module burst_sram_sync_port_bench;
    localparam int AW = 8;
    localparam int W = 18;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic k_clk = 1'b0;
    logic pll_disable_n = 1'b1;
    logic load_strobe_n;
    logic read_not_write;
    logic [AW-1:0] addr;
    logic [1:0] byte_lane_select_n;
    logic [W-1:0] dq_in;
    logic [W-1:0] dq_out;
    logic dq_oe;
    logic legacy_mode;
    logic [15:0] read_burst_count;
    logic [15:0] write_burst_count;
    logic [W-1:0] m0 [int];
    logic [W-1:0] m1 [int];
    logic [31:0] seed = 32'h0000_ac1b;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int nr = 0;
    int nw = 0;

    // ************************************************************
    // Clocks, design and controller.
    // ************************************************************
    // The link clock is offset so its edges never meet the system clock's.
    initial forever #5 clk = ~clk;
    initial
    begin
        #2.7;
        forever #32 k_clk = ~k_clk;
    end

    bssp_top #(.WIDTH(W), .ADDR_W(AW), .CNT_W(16)) bssp_top_i (.clk(clk), .rst(rst),
        .k_clk(k_clk), .k_n_clk(~k_clk), .load_strobe_n(load_strobe_n),
        .read_not_write(read_not_write), .addr(addr), .byte_lane_select_n(byte_lane_select_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .output_valid_flag(), .echo_clock(),
        .echo_clock_n(), .pll_disable_n(pll_disable_n), .legacy_mode(legacy_mode),
        .read_burst_count(read_burst_count), .write_burst_count(write_burst_count));

    bssp_ctrl #(.AW(AW), .W(W)) bssp_ctrl_i (.k_clk(k_clk), .legacy(~pll_disable_n),
        .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .addr(addr),
        .byte_lane_select_n(byte_lane_select_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    // ************************************************************
    // Helpers.
    // ************************************************************
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // A deselected lane keeps its stored bits.
    function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [W-1:0] nv,
        input logic [1:0] s);
        merge = old;
        if (!s[0]) merge[8:0] = nv[8:0];
        if (!s[1]) merge[17:9] = nv[17:9];
    endfunction : merge

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // A hang is cut short well beyond the few thousand cycles the run needs.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end

    // ************************************************************
    // Main sequence: full latency first, then legacy mode.
    // ************************************************************
    initial
    begin : main
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic [W-1:0] w0;
        logic [W-1:0] w1;
        logic [1:0] v;
        logic [AW-1:0] a;
        repeat (30) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int md = 0; md < 2; md++)
        begin
            pll_disable_n = (md == 0);
            repeat (8) @(posedge k_clk);
            #1;
            chk(legacy_mode, md);
            for (int i = 0; i < 8; i++)
            begin
                a = AW'(rnd());
                d0 = W'(rnd());
                d1 = W'(rnd());
                bssp_ctrl_i.wr(a, d0, d1, 2'b00, 2'b00);
                m0[a] = d0;
                m1[a] = d1;
                d0 = W'(rnd());
                d1 = W'(rnd());
                bssp_ctrl_i.wr(a, d0, d1, 2'(i), 2'(i + 1));
                m0[a] = merge(m0[a], d0, 2'(i));
                m1[a] = merge(m1[a], d1, 2'(i + 1));
                nw += 2;
                bssp_ctrl_i.rd(a, w0, w1, v);
                nr++;
                chk(w0, m0[a]);
                chk(w1, m1[a]);
                chk(v, 2'b11);
                d0 = W'(rnd());
                d1 = W'(rnd());
                bssp_ctrl_i.wr_rd(a, d0, d1, 2'(i + 2), 2'(i + 3), w0, w1, v);
                m0[a] = merge(m0[a], d0, 2'(i + 2));
                m1[a] = merge(m1[a], d1, 2'(i + 3));
                nw++;
                nr++;
                chk(w0, m0[a]);
                chk(w1, m1[a]);
                chk(v, 2'b11);
            end
        end
        repeat (20) @(posedge clk);
        chk(read_burst_count, nr);
        chk(write_burst_count, nw);
        stop_test();
    end
endmodule : burst_sram_sync_port_bench

`default_nettype wire
